// ### core/dlic_top.sv
// Notes on behaviour
// - Sources latch pending until gone and cleared
// - Routing one selects fast, zero normal
// - Enable zero keeps source off both lines; pending still latches
// - Polarity one falling edge, zero rising
// - Polarity ignored for internal sources
// - Fast view is pending, enabled, fast-routed
// - Normal view is pending, enabled, normal-routed
// - All registers but the two event registers share pending bit layout
// - Timing sources occupy bits zero to five
// - DMA bits eight to twelve, core thirteen
// - Serial and keypad sources at fixed bits
// - Port B pins mapped; reserved bits zero
// - Drive fast or normal request to core
//
// Implementation choices: the APB register port and the address map.
module dlic_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_a_irq,
    input wire logic timer_b_irq,
    input wire logic data_port_baud_generator_irq,
    input wire logic debug_port_baud_generator_irq,
    input wire logic clock_alarm_irq,
    input wire logic smart_card_interface_irq,
    input wire logic [4:0] dma_done_irq,
    input wire logic signal_core_irq,
    input wire logic data_port_tx_irq,
    input wire logic data_port_start_bit_irq,
    input wire logic data_port_rx_irq,
    input wire logic debug_tx_irq,
    input wire logic rate_detect_irq,
    input wire logic debug_rx_irq,
    input wire logic key_press_irq,
    input wire logic [7:0] port_b_pin,
    output logic fast_irq,
    output logic normal_irq,
    output logic evt_irq
);
    logic wr_stb; // Write strobe, access phase
    logic rd_stb; // Read strobe, access phase
    logic [7:0] reg_addr; // Decoded offset
    logic addr_ok; // Offset mapped
    logic [31:0] pending_r; // Latched sources
    logic [31:0] line_select_r; // Fast routing
    logic [31:0] enable_r; // Per source enable
    logic [31:0] polarity_r; // External edge choice
    logic [31:0] fast_status; // Fast line view
    logic [31:0] normal_status; // Normal line view
    logic [31:0] src_level; // Internal source levels
    logic [31:0] src_edge; // External edge pulses
    logic [31:0] src_now; // Sources present now
    logic [31:0] clr_req; // Write-one clear request
    logic [7:0] pin_falling; // Per pin polarity
    logic [7:0] pin_edge; // Per pin edge pulse
    logic [1:0] evt_status_r; // Sticky line events
    logic [1:0] evt_mask_r; // Event mask
    logic [1:0] evt_set; // Line rising events
    logic fast_q_r; // Previous fast level
    logic normal_q_r; // Previous normal level
    logic wr_pend_hit; // Write aimed at pending
    logic wr_evt_stat_hit; // Write aimed at event status
    logic wr_evt_mask_hit; // Write aimed at event mask

    // Write strobe aimed at one offset
    function automatic logic wr_hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
    begin
        wr_hit = stb && (a == off);
    end
    endfunction

    // One line view: pending, enabled, routed to that line
    function automatic logic [31:0] line_view(input logic [31:0] pend, input logic [31:0] en,
        input logic [31:0] route);
    begin
        line_view = pend & en & route;
    end
    endfunction

    // Bus front end
    dlic_apb_if u_apb
    (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .reg_addr(reg_addr),
        .addr_ok(addr_ok)
    );

    // Pin polarity per pin from its source bit
    // Only the eight external positions feed the pins
    // only external bits used
    always_comb
    begin
        pin_falling[0] = polarity_r[dlic_pkg::BIT_PB0];
        pin_falling[1] = polarity_r[dlic_pkg::BIT_PB1];
        pin_falling[2] = polarity_r[dlic_pkg::BIT_PB2];
        pin_falling[3] = polarity_r[dlic_pkg::BIT_PB3];
        pin_falling[4] = polarity_r[dlic_pkg::BIT_PB4];
        pin_falling[5] = polarity_r[dlic_pkg::BIT_PB5];
        pin_falling[6] = polarity_r[dlic_pkg::BIT_PB6];
        pin_falling[7] = polarity_r[dlic_pkg::BIT_PB7];
    end

    // Pins may move at any time, so they are
    // retimed before any edge is judged
    // double flop then edge
    dlic_pin_sync u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(port_b_pin),
        .falling_sel(pin_falling),
        .edge_hit(pin_edge)
    );

    // Map internal sources onto their bits
    // Internal sources are levels; unused bits stay zero
    // internal source positions
    always_comb
    begin
        src_level = 32'h0000_0000;
        src_level[dlic_pkg::BIT_TIMER_A] = timer_a_irq;
        src_level[dlic_pkg::BIT_TIMER_B] = timer_b_irq;
        src_level[dlic_pkg::BIT_DATA_PORT_BAUD] = data_port_baud_generator_irq;
        src_level[dlic_pkg::BIT_DEBUG_PORT_BAUD] = debug_port_baud_generator_irq;
        src_level[dlic_pkg::BIT_CLOCK_ALARM] = clock_alarm_irq;
        src_level[dlic_pkg::BIT_SMART_CARD] = smart_card_interface_irq;
        src_level[dlic_pkg::BIT_DMA0 +: 5] = dma_done_irq;
        src_level[dlic_pkg::BIT_SIGNAL_CORE] = signal_core_irq;
        src_level[dlic_pkg::BIT_DATA_TX] = data_port_tx_irq;
        src_level[dlic_pkg::BIT_DATA_START] = data_port_start_bit_irq;
        src_level[dlic_pkg::BIT_DATA_RX] = data_port_rx_irq;
        src_level[dlic_pkg::BIT_DEBUG_TX] = debug_tx_irq;
        src_level[dlic_pkg::BIT_RATE_DET] = rate_detect_irq;
        src_level[dlic_pkg::BIT_DEBUG_RX] = debug_rx_irq;
        src_level[dlic_pkg::BIT_KEY_PRESS] = key_press_irq;
    end

    // Map pin edges onto their bits
    // Each edge is a single-cycle pulse here
    // port B positions
    always_comb
    begin
        src_edge = 32'h0000_0000;
        src_edge[dlic_pkg::BIT_PB0] = pin_edge[0];
        src_edge[dlic_pkg::BIT_PB1] = pin_edge[1];
        src_edge[dlic_pkg::BIT_PB2] = pin_edge[2];
        src_edge[dlic_pkg::BIT_PB3] = pin_edge[3];
        src_edge[dlic_pkg::BIT_PB4] = pin_edge[4];
        src_edge[dlic_pkg::BIT_PB5] = pin_edge[5];
        src_edge[dlic_pkg::BIT_PB6] = pin_edge[6];
        src_edge[dlic_pkg::BIT_PB7] = pin_edge[7];
    end

    // Source presence, reserved bits forced zero
    assign src_now = (src_level | src_edge) & dlic_pkg::SRC_MASK;

    // Offset decode for the write-one-clear registers and the event mask
    // Shared by pending clear and the event registers
    assign wr_pend_hit = wr_hit(wr_stb, reg_addr, dlic_pkg::OFF_PENDING);
    assign wr_evt_stat_hit = wr_hit(wr_stb, reg_addr, dlic_pkg::OFF_EVT_STATUS);
    assign wr_evt_mask_hit = wr_hit(wr_stb, reg_addr, dlic_pkg::OFF_EVT_MASK);

    // Clear request from write of ones
    // Bits written as zero leave pending alone
    assign clr_req = wr_pend_hit ? pwdata : 32'h0000_0000;

    // Pending latch; a present source beats clear
    // A source still high re-sets its bit every edge,
    // so a clear during the event is lost on purpose
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pending_r <= dlic_pkg::RST_ZERO;
        end
        else
        begin
            pending_r <= ((pending_r & ~clr_req) | src_now) & dlic_pkg::SRC_MASK;
        end
    end

    // Configuration registers
    // shared bit layout
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_select_r <= dlic_pkg::RST_ZERO;
            enable_r <= dlic_pkg::RST_ZERO;
            polarity_r <= dlic_pkg::RST_ZERO;
        end
        else if (wr_stb)
        begin
            case (reg_addr)
                // Routing: one picks the fast line
                dlic_pkg::OFF_LINE_SELECT:
                begin
                    line_select_r <= pwdata & dlic_pkg::SRC_MASK;
                end
                // Enable: reserved bits never stored
                dlic_pkg::OFF_ENABLE:
                begin
                    enable_r <= pwdata & dlic_pkg::SRC_MASK;
                end
                // internal polarity bits not stored
                // A polarity flip alone cannot fake an edge; a pin level change is needed
                dlic_pkg::OFF_POLARITY:
                begin
                    polarity_r <= pwdata & dlic_pkg::EXT_MASK;
                end
                // Other offsets leave configuration alone
                default:
                begin
                    polarity_r <= polarity_r;
                end
            endcase
        end
    end

    // Line views
    // enable gates the source
    assign fast_status = line_view(pending_r, enable_r, line_select_r);
    assign normal_status = line_view(pending_r, enable_r, ~line_select_r);

    // Request outputs to core, registered
    // Flopped so the core never sees decode glitches
    // Costs one cycle after pending sets
    // drive fast or normal request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fast_irq <= 1'b0;
            normal_irq <= 1'b0;
        end
        else
        begin
            fast_irq <= |fast_status;
            normal_irq <= |normal_status;
        end
    end

    // Line rising event detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fast_q_r <= 1'b0;
            normal_q_r <= 1'b0;
        end
        else
        begin
            fast_q_r <= fast_irq;
            normal_q_r <= normal_irq;
        end
    end
    // Fast line rise, slot zero
    assign evt_set[dlic_pkg::EVT_FAST] = fast_irq & ~fast_q_r;
    // Normal line rise, slot one
    assign evt_set[dlic_pkg::EVT_NORMAL] = normal_irq & ~normal_q_r;

    // Sticky events, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_status_r <= 2'h0;
        end
        else if (wr_evt_stat_hit)
        begin
            evt_status_r <= (evt_status_r & ~pwdata[1:0]) | evt_set;
        end
        else
        begin
            evt_status_r <= evt_status_r | evt_set;
        end
    end

    // Event mask register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_mask_r <= 2'h0;
        end
        else if (wr_evt_mask_hit)
        begin
            evt_mask_r <= pwdata[1:0] & dlic_pkg::EVT_MASK_BITS;
        end
    end

    // Level event interrupt
    assign evt_irq = |(evt_status_r & evt_mask_r);

    // Read data mux, combinational in access phase
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd_stb)
        begin
            case (reg_addr)
                dlic_pkg::OFF_PENDING:
                    prdata = pending_r;
                dlic_pkg::OFF_LINE_SELECT:
                    prdata = line_select_r;
                dlic_pkg::OFF_ENABLE:
                    prdata = enable_r;
                dlic_pkg::OFF_POLARITY:
                    prdata = polarity_r;
                dlic_pkg::OFF_FAST_STATUS:
                    prdata = fast_status;
                dlic_pkg::OFF_NORMAL_STATUS:
                    prdata = normal_status;
                // Event registers padded to a full word
                dlic_pkg::OFF_EVT_STATUS:
                    prdata = {30'h0, evt_status_r};
                dlic_pkg::OFF_EVT_MASK:
                    prdata = {30'h0, evt_mask_r};
                // Unmapped reads return zero
                default:
                    prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule

// ### core/dlic_pkg.sv
package dlic_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_PENDING = 8'h00;
    localparam logic [7:0] OFF_LINE_SELECT = 8'h04;
    localparam logic [7:0] OFF_ENABLE = 8'h08;
    localparam logic [7:0] OFF_POLARITY = 8'h0c;
    localparam logic [7:0] OFF_FAST_STATUS = 8'h10;
    localparam logic [7:0] OFF_NORMAL_STATUS = 8'h14;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h18;
    localparam logic [7:0] OFF_EVT_MASK = 8'h1c;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // Source bit positions
    localparam int BIT_TIMER_A = 0;
    localparam int BIT_TIMER_B = 1;
    localparam int BIT_DATA_PORT_BAUD = 2;
    localparam int BIT_DEBUG_PORT_BAUD = 3;
    localparam int BIT_CLOCK_ALARM = 4;
    localparam int BIT_SMART_CARD = 5;
    localparam int BIT_DMA0 = 8;
    localparam int BIT_SIGNAL_CORE = 13;
    localparam int BIT_DATA_TX = 14;
    localparam int BIT_DATA_START = 15;
    localparam int BIT_DATA_RX = 16;
    localparam int BIT_DEBUG_TX = 18;
    localparam int BIT_RATE_DET = 19;
    localparam int BIT_DEBUG_RX = 20;
    localparam int BIT_KEY_PRESS = 24;
    localparam int BIT_PB0 = 17;
    localparam int BIT_PB1 = 27;
    localparam int BIT_PB2 = 7;
    localparam int BIT_PB3 = 21;
    localparam int BIT_PB4 = 23;
    localparam int BIT_PB5 = 22;
    localparam int BIT_PB6 = 28;
    localparam int BIT_PB7 = 26;
    // Implemented sources; bits 6, 25, 29..31 stay zero
    localparam logic [31:0] SRC_MASK = 32'h1dff_ffbf;
    // External (pin) positions
    localparam logic [31:0] EXT_MASK = 32'h1ce2_0080;
    // Event status bit positions
    localparam int EVT_FAST = 0;
    localparam int EVT_NORMAL = 1;
    localparam logic [1:0] EVT_MASK_BITS = 2'h3;
endpackage

// ### core/dlic_pin_sync.sv
// Two-stage synchroniser with edge detection per port B pin
module dlic_pin_sync
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] falling_sel,
    output logic [7:0] edge_hit
);
    logic [7:0] meta_r; // First stage, read only by second
    logic [7:0] sync_r; // Second stage
    logic [7:0] last_r; // Previous synced level

    // Synchroniser chain and history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= 8'h00;
            sync_r <= 8'h00;
            last_r <= 8'h00;
        end
        else
        begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Chosen edge, one cycle pulse per edge
    always_comb
    begin
        edge_hit = (falling_sel & last_r & ~sync_r) | (~falling_sel & ~last_r & sync_r);
    end
endmodule

// ### core/dlic_apb_if.sv
// APB slave front end: decode, zero wait, strobes
module dlic_apb_if
(
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    output logic pready,
    output logic pslverr,
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] reg_addr,
    output logic addr_ok
);
    // Known offsets only
    always_comb
    begin
        case (paddr)
            dlic_pkg::OFF_PENDING, dlic_pkg::OFF_LINE_SELECT, dlic_pkg::OFF_ENABLE,
            dlic_pkg::OFF_POLARITY, dlic_pkg::OFF_FAST_STATUS, dlic_pkg::OFF_NORMAL_STATUS,
            dlic_pkg::OFF_EVT_STATUS, dlic_pkg::OFF_EVT_MASK:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // Always ready in access phase
    assign pready = 1'b1;
    // Unmapped address errors
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_stb = psel & penable & pwrite & addr_ok;
    assign rd_stb = psel & penable & ~pwrite & addr_ok;
    assign reg_addr = paddr;
endmodule

// ### test/dlic_sva.sv
// Port-level checks on the interrupt controller
module dlic_sva
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timer_a_irq,
    input wire logic fast_irq,
    input wire logic normal_irq
);
    // One clock domain
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Read access phase
    wire logic rd_acc;
    assign rd_acc = psel && penable && !pwrite;

    a_pready_high: assert property (
        psel && penable |-> pready) else $error("pready low in access phase");
    a_unmapped_err: assert property (
        psel && penable && paddr > 8'h1c |-> pslverr) else $error("no error on unmapped address");
    a_mapped_ok: assert property (
        psel && penable && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped address");
    a_unmapped_zero: assert property (
        rd_acc && pslverr |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_reserved_zero: assert property (
        rd_acc && paddr <= 8'h14 |-> (prdata & ~dlic_pkg::SRC_MASK) == 32'h0) else $error("reserved bit set");
    a_polarity_ext: assert property (
        rd_acc && paddr == 8'h0c |-> (prdata & ~dlic_pkg::EXT_MASK) == 32'h0) else $error("internal polarity bit kept");
    a_timer_latch: assert property (
        rd_acc && paddr == 8'h00 && $past(timer_a_irq) && $past(presetn) |-> prdata[0]) else $error("timer not latched");
    a_fast_follow: assert property (
        rd_acc && paddr == 8'h10 |=> fast_irq == ($past(prdata) != 32'h0)) else $error("fast line mismatch");
    a_normal_follow: assert property (
        rd_acc && paddr == 8'h14 |=> normal_irq == ($past(prdata) != 32'h0)) else $error("normal line mismatch");
endmodule

// ### test/dlic_host_model.sv
// Host core: takes fast and normal requests
module dlic_host_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fast_irq,
    input wire logic normal_irq,
    output logic in_fast,
    output logic in_normal
);
    timeunit 1ns;
    timeprecision 1ps;
    // Service state per line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_fast <= 1'b0;
            in_normal <= 1'b0;
        end
        else
        begin
            in_fast <= fast_irq;
            in_normal <= normal_irq && !fast_irq && !in_fast;
        end
    end
endmodule

// ### test/tb_top.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, pins = 8'h00;
    logic [31:0] pwdata = 32'h0, src = 32'h0, prdata, rd, ex, en, sel;
    logic pready, pslverr, fast_irq, normal_irq, evt_irq, er, r, h_fast, h_norm;
    int n_mismatch = 0, n_checks = 0;
    int pmap[8] = '{17, 27, 7, 21, 23, 22, 28, 26}; // Pin to pending bit
    logic [31:0] in_m = dlic_pkg::SRC_MASK & ~dlic_pkg::EXT_MASK; // Internal sources
    always #25 pclk = ~pclk;
    dlic_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .timer_a_irq(src[0]), .timer_b_irq(src[1]), .data_port_baud_generator_irq(src[2]),
        .debug_port_baud_generator_irq(src[3]), .clock_alarm_irq(src[4]), .smart_card_interface_irq(src[5]),
        .dma_done_irq(src[12:8]), .signal_core_irq(src[13]), .data_port_tx_irq(src[14]),
        .data_port_start_bit_irq(src[15]), .data_port_rx_irq(src[16]), .debug_tx_irq(src[18]),
        .rate_detect_irq(src[19]), .debug_rx_irq(src[20]), .key_press_irq(src[24]), .port_b_pin(pins),
        .fast_irq, .normal_irq, .evt_irq);
    dlic_host_model i_host (.pclk, .presetn, .fast_irq, .normal_irq, .in_fast(h_fast), .in_normal(h_norm));
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 100);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    // One-cycle pulse on internal sources
    task automatic pulse(input logic [31:0] v);
        src <= v;
        @(posedge pclk);
        src <= 32'h0;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #2000000;
        n_mismatch++;
        final_report;
    end
    // Main sequence
    initial
    begin
        void'($urandom(32'hcc59));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 32; a += 4) rdc("reset", a[7:0], 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            ex = $urandom;
            wr(8'h04, ex); rdc("select", 8'h04, ex & dlic_pkg::SRC_MASK);
            wr(8'h0c, ex); rdc("polarity", 8'h0c, ex & dlic_pkg::EXT_MASK);
        end
        wr(8'h0c, 32'h0);
        wr(8'h10, 32'hffff_ffff); rdc("ro fast", 8'h10, 32'h0);
        rdc("unmapped", 8'h24, 32'h0); `CHK("slverr", 1'b1, er)
        $display("test layout done");
        for (int b = 0; b < 32; b++) if (in_m[b])
        begin
            pulse(32'h1 << b);
            rdc("pending", 8'h00, 32'h1 << b);
            wr(8'h00, 32'h1 << b); rdc("cleared", 8'h00, 32'h0);
        end
        src <= 32'h1; wr(8'h00, 32'h1); rdc("source wins", 8'h00, 32'h1);
        src <= 32'h0; wr(8'h00, 32'h1); rdc("clear late", 8'h00, 32'h0);
        $display("test pending done");
        for (int i = 0; i < 4; i++)
        begin
            en = $urandom; sel = $urandom;
            wr(8'h04, sel); wr(8'h08, en); pulse(in_m);
            ex = in_m & en & sel;
            rdc("fast view", 8'h10, ex);
            rdc("normal view", 8'h14, in_m & en & ~sel);
            `CHK("fast line", |ex, fast_irq)
            `CHK("host fast", |ex, h_fast)
            `CHK("host normal", (|(in_m & en & ~sel)) && !(|ex), h_norm)
            wr(8'h08, 32'h0); wr(8'h00, 32'hffff_ffff);
        end
        $display("test routing done");
        for (int i = 0; i < 8; i++)
        begin
            r = $urandom;
            wr(8'h0c, {31'h0, r} << pmap[i]); pins[i] <= r;
            repeat (4) @(posedge pclk);
            wr(8'h00, 32'hffff_ffff); pins[i] <= ~r;
            repeat (4) @(posedge pclk);
            rdc("pin edge", 8'h00, 32'h1 << pmap[i]);
            wr(8'h00, 32'hffff_ffff); pins[i] <= r;
            repeat (4) @(posedge pclk);
            rdc("wrong edge", 8'h00, 32'h0);
        end
        $display("test pins done");
        wr(8'h18, 32'h3); rdc("evt idle", 8'h18, 32'h0);
        wr(8'h1c, 32'h3); wr(8'h04, 32'h1); wr(8'h08, 32'h1); pulse(32'h1);
        repeat (3) @(posedge pclk);
        `CHK("evt raised", 1'b1, evt_irq)
        wr(8'h08, 32'h0); wr(8'h00, 32'h1); wr(8'h18, 32'h3);
        repeat (2) @(posedge pclk);
        `CHK("evt cleared", 1'b0, evt_irq)
        wr(8'h1c, 32'h0); wr(8'h08, 32'h1); pulse(32'h1);
        repeat (3) @(posedge pclk);
        `CHK("evt masked", 1'b0, evt_irq)
        rdc("evt status", 8'h18, 32'h1);
        $display("test events done");
        final_report;
    end
endmodule
bind dlic_top dlic_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .timer_a_irq, .fast_irq, .normal_irq);
